// ### logic/pse_alert_pkg.sv
// Command codes, field positions and reset values of the alert logic
package pse_alert_pkg;
   // Command codes of the register port
   localparam logic [7:0] CMD_SUMMARY = 8'h00;
   localparam logic [7:0] CMD_MASK = 8'h01;
   localparam logic [7:0] CMD_PWR_EVT = 8'h02;
   localparam logic [7:0] CMD_PWR_EVT_CLR = 8'h03;
   localparam logic [7:0] CMD_DET_EVT = 8'h04;
   localparam logic [7:0] CMD_DET_EVT_CLR = 8'h05;
   localparam logic [7:0] CMD_FLT_EVT = 8'h06;
   localparam logic [7:0] CMD_FLT_EVT_CLR = 8'h07;
   localparam logic [7:0] CMD_STI_EVT = 8'h08;
   localparam logic [7:0] CMD_STI_EVT_CLR = 8'h09;
   // Reset values and unmapped read data
   localparam logic [7:0] SUMMARY_RST = 8'h80;
   localparam logic [7:0] MASK_RST = 8'h80;
   localparam logic [7:0] PWR_EVT_RST = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
   // Summary and mask bit positions
   localparam int BIT_SUPPLY = 7;
   localparam int BIT_START = 6;
   localparam int BIT_OVERCUR = 5;
   localparam int BIT_CLASS = 4;
   localparam int BIT_DETECT = 3;
   localparam int BIT_DISCON = 2;
   localparam int BIT_PGOOD = 1;
   localparam int BIT_PENABLE = 0;
   // Power change register fields
   localparam int NUM_CH = 4;
   localparam int PG_LSB = 4;
   localparam int PE_LSB = 0;
   // Layout of the watched event flag vector
   localparam int DET_BASE = 0;
   localparam int FLT_BASE = 8;
   localparam int STI_BASE = 16;
   localparam int PAIR_BASE = 24;
   localparam int EVT_W = 26;
endpackage

// ### logic/flag_rise_detect.sv
// Registered rising-edge detector for a vector of event flags
`timescale 1ns/1ps
`default_nettype none
module flag_rise_detect #(
   parameter int W = 26
) (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic [W-1:0] flags_in,
   output logic [W-1:0] rise_out
);
   logic [W-1:0] prev_reg;

   if (W < 1) begin : g_chk
      $error("flag_rise_detect needs W of at least 1");
   end

   // Remember the flags and mark bits that went high
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prev_reg <= '0;
         rise_out <= '0;
      end else begin
         prev_reg <= flags_in;
         rise_out <= flags_in & ~prev_reg;
      end
   end
endmodule
`default_nettype wire

// ### logic/power_change_events.sv
// Per-channel power-enable and power-good change flags with clear
`timescale 1ns/1ps
`default_nettype none
module power_change_events #(
   parameter int CH = 4
) (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic [CH-1:0] power_enable_in,
   input wire logic [CH-1:0] power_good_in,
   input wire logic [CH/2-1:0] four_pair_in,
   input wire logic [CH/2-1:0] single_sig_in,
   input wire logic clear_in,
   output logic [2*CH-1:0] flags_out,
   output logic pe_set_out,
   output logic pg_set_out
);
   logic [CH-1:0] en_prev_reg;
   logic [CH-1:0] good_prev_reg;
   logic [CH-1:0] pend_reg;
   logic [CH-1:0] pend_next;
   logic [CH-1:0] pg_set;
   logic [CH-1:0] pe_set;

   if (CH < 2 || CH % 2 != 0) begin : g_chk
      $error("power_change_events needs an even channel count");
   end

   // Enable changes are flagged per channel, paired or not
   assign pe_set = power_enable_in ^ en_prev_reg;

   // Good changes of a single-signature pair wait for both channels
   for (genvar p = 0; p < CH/2; p++) begin : g_pair
      logic [1:0] chg;
      logic both;
      assign chg = power_good_in[2*p +: 2] ^ good_prev_reg[2*p +: 2];
      assign both = &(pend_reg[2*p +: 2] | chg);
      // Single-signature pair sets both flags at once, else per channel
      assign pg_set[2*p +: 2] = (four_pair_in[p] && single_sig_in[p]) ?
         (both ? 2'h3 : 2'h0) : chg;
      assign pend_next[2*p +: 2] = (four_pair_in[p] && single_sig_in[p] &&
         !both) ? (pend_reg[2*p +: 2] | chg) : 2'h0;
   end

   // Status history and pending pair changes
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         en_prev_reg <= '0;
         good_prev_reg <= '0;
         pend_reg <= '0;
      end else begin
         en_prev_reg <= power_enable_in;
         good_prev_reg <= power_good_in;
         pend_reg <= pend_next;
      end
   end

   // Set terms reach the summary on the same edge as the flags, so a
   // clearing read can never leave a summary bit without its flag
   assign pe_set_out = |pe_set;
   assign pg_set_out = |pg_set;

   // Flags: a new change wins over a clearing read
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         flags_out <= (2*CH)'(pse_alert_pkg::PWR_EVT_RST);
      end else begin
         flags_out <= (clear_in ? '0 : flags_out) |
            {pg_set, pe_set};
      end
   end
endmodule
`default_nettype wire

// ### logic/pse_event_alert_logic.sv
// Event summary, alert mask and power change register of the controller
// Contract
// - Read-only eight-bit summary at 00h, active-high category bits.
// - Clearing event reads or reset command clear the matching summary bits.
// - Alert active when summary bit, its mask bit and global enable set.
// - Bit 7 ORs thermal, logic and power supply, memory faults; resets one.
// - Bit 6 ORs the four start-timeout flags.
// - Bit 5 ORs overload, pair overload and current-limit flags.
// - Bit 4 ORs the four classification event flags.
// - Bit 3 ORs the four detection event flags.
// - Bit 2 ORs the four disconnect event flags.
// - Bit 1 ORs the four power-good change flags.
// - Bit 0 ORs the four power-enable change flags.
// - Mask at 01h read/write, same bit positions, resets to 80h.
// - Summary follows events regardless of mask; mask gates only alert.
// - Power change register at 02h plain read, 03h read clears.
// - Clearing read releases alert when no other unmasked cause remains.
// - Power change bits 7-4 good changes, 3-0 enable changes; reset zero.
// - Four-pair ports flag enable changes per channel.
// - Single-signature pairs flag good changes after both channels change.
// - Dual-signature pairs flag each channel independently.
// - Detection and class flags readable without clearing at 04h.
// - Disconnect and overload flags readable without clearing at 06h.
// - Current-limit and start-timeout flags read without clearing at 08h.
`timescale 1ns/1ps
`default_nettype none
module pse_event_alert_logic (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic reg_rd_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_cmd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   input wire logic global_alert_enable_in,
   input wire logic summary_clear_in,
   input wire logic thermal_shutdown_in,
   input wire logic logic_supply_undervoltage_in,
   input wire logic logic_supply_warning_in,
   input wire logic power_supply_undervoltage_in,
   input wire logic memory_fault_in,
   input wire logic [7:0] detect_events_in,
   input wire logic [7:0] fault_events_in,
   input wire logic [7:0] start_ilim_events_in,
   input wire logic [1:0] pair_overload_flag_in,
   input wire logic [3:0] chan_power_enable_in,
   input wire logic [3:0] chan_power_good_in,
   input wire logic [1:0] four_pair_in,
   input wire logic [1:0] single_sig_in,
   output logic detect_clear_out,
   output logic fault_clear_out,
   output logic start_ilim_clear_out,
   output logic alert_n_out
);
   logic [7:0] summary_reg;
   logic [7:0] summary_next;
   logic [7:0] mask_reg;
   logic [7:0] sum_set;
   logic [7:0] sum_clr;
   logic [7:0] pwr_flags;
   logic [7:0] rdata_next;
   logic [pse_alert_pkg::EVT_W-1:0] evt_rise;
   logic pe_set;
   logic pg_set;
   logic pwr_clear;
   logic supply_fault;
   logic alert_cond;

   // Rising edges of the other event registers' flags
   flag_rise_detect #(
      .W(pse_alert_pkg::EVT_W)
   ) u_rise (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .flags_in({pair_overload_flag_in, start_ilim_events_in,
                 fault_events_in, detect_events_in}),
      .rise_out(evt_rise)
   );

   // Clearing read of the power change register
   assign pwr_clear = reg_rd_in &&
      (reg_cmd_in == pse_alert_pkg::CMD_PWR_EVT_CLR);

   // Power change register
   power_change_events #(
      .CH(pse_alert_pkg::NUM_CH)
   ) u_pwr (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .power_enable_in(chan_power_enable_in),
      .power_good_in(chan_power_good_in),
      .four_pair_in(four_pair_in),
      .single_sig_in(single_sig_in),
      .clear_in(pwr_clear),
      .flags_out(pwr_flags),
      .pe_set_out(pe_set),
      .pg_set_out(pg_set)
   );

   assign supply_fault = thermal_shutdown_in | logic_supply_undervoltage_in |
      logic_supply_warning_in | power_supply_undervoltage_in |
      memory_fault_in;

   // Category set terms, independent of the mask
   always_comb begin
      sum_set = 8'h00;
      sum_set[pse_alert_pkg::BIT_SUPPLY] = supply_fault;
      sum_set[pse_alert_pkg::BIT_START] =
         |evt_rise[pse_alert_pkg::STI_BASE +: 4];
      sum_set[pse_alert_pkg::BIT_OVERCUR] =
         |evt_rise[pse_alert_pkg::FLT_BASE +: 4] |
         |evt_rise[pse_alert_pkg::PAIR_BASE +: 2] |
         |evt_rise[pse_alert_pkg::STI_BASE + 4 +: 4];
      sum_set[pse_alert_pkg::BIT_CLASS] =
         |evt_rise[pse_alert_pkg::DET_BASE + 4 +: 4];
      sum_set[pse_alert_pkg::BIT_DETECT] =
         |evt_rise[pse_alert_pkg::DET_BASE +: 4];
      sum_set[pse_alert_pkg::BIT_DISCON] =
         |evt_rise[pse_alert_pkg::FLT_BASE + 4 +: 4];
      sum_set[pse_alert_pkg::BIT_PGOOD] = pg_set;
      sum_set[pse_alert_pkg::BIT_PENABLE] = pe_set;
   end

   // Category clear terms from clearing reads and the reset command
   always_comb begin
      sum_clr = 8'h00;
      if (summary_clear_in) begin
         sum_clr = 8'hFF;
      end else if (reg_rd_in) begin
         if (reg_cmd_in == pse_alert_pkg::CMD_PWR_EVT_CLR) begin
            sum_clr[pse_alert_pkg::BIT_PGOOD] = 1'b1;
            sum_clr[pse_alert_pkg::BIT_PENABLE] = 1'b1;
         end else if (reg_cmd_in == pse_alert_pkg::CMD_DET_EVT_CLR) begin
            sum_clr[pse_alert_pkg::BIT_CLASS] = 1'b1;
            sum_clr[pse_alert_pkg::BIT_DETECT] = 1'b1;
         end else if (reg_cmd_in == pse_alert_pkg::CMD_FLT_EVT_CLR) begin
            sum_clr[pse_alert_pkg::BIT_DISCON] = 1'b1;
            sum_clr[pse_alert_pkg::BIT_OVERCUR] = 1'b1;
         end else if (reg_cmd_in == pse_alert_pkg::CMD_STI_EVT_CLR) begin
            sum_clr[pse_alert_pkg::BIT_START] = 1'b1;
            sum_clr[pse_alert_pkg::BIT_OVERCUR] = 1'b1;
         end
      end
   end

   // A set in the same cycle wins over a clear
   assign summary_next = (summary_reg & ~sum_clr) | sum_set;

   // Summary register
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         summary_reg <= pse_alert_pkg::SUMMARY_RST;
      end else begin
         summary_reg <= summary_next;
      end
   end

   // Mask register, written by the host
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mask_reg <= pse_alert_pkg::MASK_RST;
      end else if (reg_wr_in &&
                   reg_cmd_in == pse_alert_pkg::CMD_MASK) begin
         mask_reg <= reg_wdata_in;
      end
   end

   // Read data selection by command code
   always_comb begin
      if (reg_cmd_in == pse_alert_pkg::CMD_SUMMARY) begin
         rdata_next = summary_reg;
      end else if (reg_cmd_in == pse_alert_pkg::CMD_MASK) begin
         rdata_next = mask_reg;
      end else if (reg_cmd_in == pse_alert_pkg::CMD_PWR_EVT ||
                   reg_cmd_in == pse_alert_pkg::CMD_PWR_EVT_CLR) begin
         rdata_next = pwr_flags;
      end else if (reg_cmd_in == pse_alert_pkg::CMD_DET_EVT ||
                   reg_cmd_in == pse_alert_pkg::CMD_DET_EVT_CLR) begin
         rdata_next = detect_events_in;
      end else if (reg_cmd_in == pse_alert_pkg::CMD_FLT_EVT ||
                   reg_cmd_in == pse_alert_pkg::CMD_FLT_EVT_CLR) begin
         rdata_next = fault_events_in;
      end else if (reg_cmd_in == pse_alert_pkg::CMD_STI_EVT ||
                   reg_cmd_in == pse_alert_pkg::CMD_STI_EVT_CLR) begin
         rdata_next = start_ilim_events_in;
      end else begin
         rdata_next = pse_alert_pkg::RDATA_UNMAPPED;
      end
   end

   // Read data holds until the next read
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         reg_rdata_out <= pse_alert_pkg::RDATA_UNMAPPED;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rdata_next;
      end
   end

   // Clear pulses to the external event registers
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         detect_clear_out <= 1'b0;
         fault_clear_out <= 1'b0;
         start_ilim_clear_out <= 1'b0;
      end else begin
         detect_clear_out <= reg_rd_in &&
            reg_cmd_in == pse_alert_pkg::CMD_DET_EVT_CLR;
         fault_clear_out <= reg_rd_in &&
            reg_cmd_in == pse_alert_pkg::CMD_FLT_EVT_CLR;
         start_ilim_clear_out <= reg_rd_in &&
            reg_cmd_in == pse_alert_pkg::CMD_STI_EVT_CLR;
      end
   end

   // Alert gating; the mask never touches the stored summary
   assign alert_cond = global_alert_enable_in &&
      |(summary_reg & mask_reg);

   // Active-low alert, released once no unmasked cause remains
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         alert_n_out <= 1'b1;
      end else begin
         alert_n_out <= !alert_cond;
      end
   end

   // Checks
   property p_alert_low;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      global_alert_enable_in && (summary_reg & mask_reg) != 8'h00
         |=> !alert_n_out;
   endproperty
   a_alert_low: assert property (p_alert_low)
      else $error("alert not driven low for an unmasked cause");

   property p_alert_release;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (!global_alert_enable_in || (summary_reg & mask_reg) == 8'h00)
         |=> alert_n_out;
   endproperty
   a_alert_release: assert property (p_alert_release)
      else $error("alert held without an unmasked cause");

   property p_plain_read;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      reg_rd_in && reg_cmd_in == pse_alert_pkg::CMD_PWR_EVT &&
         !pe_set && !pg_set |=> $stable(pwr_flags);
   endproperty
   a_plain_read: assert property (p_plain_read)
      else $error("plain read changed power change flags");

   property p_clear_read;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      pwr_clear && !pe_set && !pg_set |=> pwr_flags == 8'h00;
   endproperty
   a_clear_read: assert property (p_clear_read)
      else $error("clearing read left power change flags set");

   property p_read_data;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (reg_rd_in && reg_cmd_in == pse_alert_pkg::CMD_PWR_EVT_CLR)
         |=> reg_rdata_out == $past(pwr_flags);
   endproperty
   a_read_data: assert property (p_read_data)
      else $error("clearing read returned wrong data");

   property p_start_summary;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      $rose(start_ilim_events_in[0]) |-> ##2 summary_reg[6];
   endproperty
   a_start_summary: assert property (p_start_summary)
      else $error("start timeout did not reach the summary");

   property p_summary_clear;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      summary_clear_in && sum_set == 8'h00 |=> summary_reg == 8'h00;
   endproperty
   a_summary_clear: assert property (p_summary_clear)
      else $error("reset command did not clear the summary");

   property p_mask_write;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      reg_wr_in && reg_cmd_in == pse_alert_pkg::CMD_MASK
         |=> mask_reg == $past(reg_wdata_in);
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("mask write not stored");

   property p_supply_summary;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      supply_fault |=> summary_reg[7];
   endproperty
   a_supply_summary: assert property (p_supply_summary)
      else $error("supply fault not in summary");

   c_alert: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
      !alert_n_out ##1 pwr_clear ##2 alert_n_out);
   c_pair_good: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
      four_pair_in[0] && single_sig_in[0] && pwr_flags[5:4] == 2'h0
         ##1 pwr_flags[5:4] == 2'h3);
   c_mask_off: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
      summary_reg[3] && !mask_reg[3] && alert_n_out);
endmodule
`default_nettype wire

// ### bench/host_reg_port.sv
// Host model that drives the command-level register port
`timescale 1ns/1ps
`default_nettype none
module host_reg_port (
   input wire logic sys_clk_in,
   input wire logic [7:0] rdata_in,
   output logic rd_out,
   output logic wr_out,
   output logic [7:0] cmd_out,
   output logic [7:0] wdata_out
);
   // Idle bus levels
   initial begin
      rd_out = 1'b0;
      wr_out = 1'b0;
      cmd_out = 8'hA5;
      wdata_out = 8'h5A;
   end
   // One read strobe; data taken after the read edge has landed
   task automatic rd_byte(input logic [7:0] cmd, output logic [7:0] data);
      @(negedge sys_clk_in);
      rd_out = 1'b1;
      cmd_out = cmd;
      @(negedge sys_clk_in);
      data = rdata_in;
      rd_out = 1'b0;
      cmd_out = ~cmd; // Idle command shows no stale value
   endtask
   // One write strobe with its data
   task automatic wr_byte(input logic [7:0] cmd, input logic [7:0] data);
      @(negedge sys_clk_in);
      wr_out = 1'b1;
      cmd_out = cmd;
      wdata_out = data;
      @(negedge sys_clk_in);
      wr_out = 1'b0;
      cmd_out = ~cmd;
      wdata_out = ~data;
   endtask
endmodule
`default_nettype wire

// ### bench/pse_event_alert_logic_tb_top.sv
// Self-checking testbench of the event summary and alert logic
`timescale 1ns/1ps
`default_nettype none
module pse_event_alert_logic_tb_top;
   logic sys_clk, rstn, gen, sclr, rd, wr, alert_n, dclr, fclr, iclr;
   logic [4:0] sup;
   logic [7:0] det, flt, sti, cmd, wdata, rdata;
   logic [3:0] pe, pg;
   logic [1:0] pair, fp, ss;
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;
   int clr_cnt = 0;

   pse_event_alert_logic pse_event_alert_logic_i (
      .sys_clk_in(sys_clk), .rstn_in(rstn), .reg_rd_in(rd), .reg_wr_in(wr),
      .reg_cmd_in(cmd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .global_alert_enable_in(gen), .summary_clear_in(sclr),
      .thermal_shutdown_in(sup[0]), .logic_supply_undervoltage_in(sup[1]),
      .logic_supply_warning_in(sup[2]),
      .power_supply_undervoltage_in(sup[3]), .memory_fault_in(sup[4]),
      .detect_events_in(det), .fault_events_in(flt),
      .start_ilim_events_in(sti), .pair_overload_flag_in(pair),
      .chan_power_enable_in(pe), .chan_power_good_in(pg),
      .four_pair_in(fp), .single_sig_in(ss), .detect_clear_out(dclr),
      .fault_clear_out(fclr), .start_ilim_clear_out(iclr),
      .alert_n_out(alert_n));

   host_reg_port host_reg_port_i (
      .sys_clk_in(sys_clk), .rdata_in(rdata), .rd_out(rd), .wr_out(wr),
      .cmd_out(cmd), .wdata_out(wdata));

   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Hang guard and count of clear pulses to the event registers
   always @(posedge sys_clk) begin
      cycles++;
      clr_cnt <= clr_cnt + int'(dclr) + int'(fclr) + int'(iclr);
      if (cycles == 20000) begin
         fails++;
         wrap_up();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Read one register and compare
   task automatic rc(input logic [7:0] c, input logic [7:0] exp);
      logic [7:0] d;
      host_reg_port_i.rd_byte(c, d);
      check(d, exp);
   endtask

   task automatic ck_alert(input logic e);
      check({7'h00, alert_n}, {7'h00, e});
   endtask

   // Covers the longest documented path: flag, summary, alert
   task automatic settle();
      repeat (3) @(negedge sys_clk);
   endtask

   task automatic pulse_clear();
      @(negedge sys_clk);
      sclr = 1'b1;
      @(negedge sys_clk);
      sclr = 1'b0;
      settle();
   endtask

   task automatic t_reset();
      settle();
      rc(8'h00, 8'h80);
      rc(8'h01, 8'h80);
      rc(8'h02, 8'h00);
      ck_alert(1'b1);
      gen = 1'b1;
      settle();
      ck_alert(1'b0);
      host_reg_port_i.wr_byte(8'h00, 8'hFF);
      rc(8'h00, 8'h80);
      rc(8'h0A, 8'h00);
      host_reg_port_i.wr_byte(8'h01, 8'h5A);
      rc(8'h01, 8'h5A);
      host_reg_port_i.wr_byte(8'h01, 8'h80);
      pulse_clear();
      rc(8'h00, 8'h00);
      ck_alert(1'b1);
      $display("t_reset done");
   endtask

   // Each supply fault source alone sets the supply category
   task automatic t_supply();
      for (int i = 0; i < 5; i++) begin
         sup[i] = 1'b1;
         settle();
         rc(8'h00, 8'h80);
         ck_alert(1'b0);
         sup[i] = 1'b0;
         pulse_clear();
         rc(8'h00, 8'h00);
      end
      $display("t_supply done");
   endtask

   // One flag source: vec 0 detect, 1 fault, 2 start/limit, 3 pair
   task automatic t_cat(input int b, input int vec, input int idx,
                        input logic [7:0] clr);
      logic [7:0] m;
      logic [7:0] src;
      int n;
      m = 8'h01 << b;
      host_reg_port_i.wr_byte(8'h01, m);
      case (vec)
         0: det[idx] = 1'b1;
         1: flt[idx] = 1'b1;
         2: sti[idx] = 1'b1;
         default: pair[idx] = 1'b1;
      endcase
      src = vec == 0 ? det : vec == 2 ? sti : flt;
      settle();
      rc(8'h00, m);
      ck_alert(1'b0);
      rc(clr - 8'h01, src);
      host_reg_port_i.wr_byte(8'h01, 8'h00);
      settle();
      ck_alert(1'b1);
      rc(8'h00, m);
      host_reg_port_i.wr_byte(8'h01, m);
      settle();
      n = clr_cnt;
      rc(clr, src);
      settle();
      ck_alert(1'b1);
      rc(8'h00, 8'h00);
      check(8'(clr_cnt - n), 8'h01);
      {det, flt, sti, pair} = '0;
      $display("t_cat bit %0d done", b);
   endtask

   task automatic t_power();
      host_reg_port_i.wr_byte(8'h01, 8'h03);
      pe[1] = 1'b1;
      settle();
      ck_alert(1'b0);
      rc(8'h02, 8'h02);
      rc(8'h02, 8'h02);
      rc(8'h00, 8'h01);
      rc(8'h03, 8'h02);
      rc(8'h02, 8'h00);
      rc(8'h00, 8'h00);
      settle();
      ck_alert(1'b1);
      pg[2] = 1'b1;
      settle();
      rc(8'h00, 8'h02);
      rc(8'h03, 8'h40);
      pe[1] = 1'b0;
      pg[2] = 1'b0;
      settle();
      rc(8'h03, 8'h42);
      rc(8'h00, 8'h00);
      $display("t_power done");
   endtask

   // Pair 1/2 four-pair single signature, pair 3/4 dual signature
   task automatic t_pairs();
      fp = 2'b11;
      ss = 2'b01;
      pg[0] = 1'b1;
      settle();
      rc(8'h02, 8'h00);
      pg[1] = 1'b1;
      settle();
      rc(8'h03, 8'h30);
      pe[0] = 1'b1;
      settle();
      rc(8'h03, 8'h01);
      pg[2] = 1'b1;
      settle();
      rc(8'h03, 8'h40);
      pe[3] = 1'b1;
      settle();
      rc(8'h03, 8'h08);
      $display("t_pairs done");
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      {gen, sclr, sup, det, flt, sti, pair, pe, pg, fp, ss} = '0;
      rstn = 1'b0;
      repeat (3) @(negedge sys_clk);
      rstn = 1'b1;
      t_reset();
      t_supply();
      t_cat(6, 2, 0, 8'h09);
      t_cat(5, 1, 1, 8'h07);
      t_cat(5, 3, 1, 8'h07);
      t_cat(5, 2, 5, 8'h09);
      t_cat(4, 0, 6, 8'h05);
      t_cat(3, 0, 2, 8'h05);
      t_cat(2, 1, 7, 8'h07);
      t_power();
      t_pairs();
      wrap_up();
   end
endmodule
`default_nettype wire
